// file: hdl/crs_clk_if.sv
/*
  Carrier between the sequencer top and its output clock generator.
  Assumes both ends run on clock_i.
*/
`timescale 1ns/10ps
`default_nettype none
interface crs_clk_if;
   logic slow_sel;   // High selects the slow internal clock.
   logic clk_out;    // Generated output clock level.

   // The top steers the choice and reads the clock.
   modport ctl (output slow_sel, input clk_out);
   // The generator obeys the choice and makes the clock.
   modport gen (input slow_sel, output clk_out);
endinterface
`default_nettype wire

// file: hdl/crs_clkgen.sv
/*
  Output clock generator: toggles every clock_i cycle for the normal
  internal clock, or every SLOW_HALF_CYC cycles for the slow clock.
  Assumes a synchronised active-low reset from the top.
*/
`timescale 1ns/10ps
`default_nettype none
module crs_clkgen (
   input  wire logic  clock_i,   // Block clock.
   input  wire logic  rst_n_i,   // Synchronised reset, active low.
   crs_clk_if.gen     clk_if     // Slow select in, clock out.
);

   // -----------------------------------------------------------------
   // State.
   // -----------------------------------------------------------------

   typedef struct packed {
      logic                       clock_out_pin;   // Clock level.
      logic [crs_pkg::SLOW_W-1:0] cnt;   // Cycles left in half period.
   } crs_gen_s;

   crs_gen_s state_r;     // Registered state.
   crs_gen_s state_nxt;   // Next state.

   // Next state: the switch between rates takes effect on the next cycle,
   // even part way through a slow half period; no half period is shorter than one cycle.
   always_comb begin
      state_nxt = state_r;
      if (clk_if.slow_sel) begin
         if (state_r.cnt == crs_pkg::SLOW_ZERO) begin
            state_nxt.clock_out_pin = ~state_r.clock_out_pin;
            state_nxt.cnt = crs_pkg::SLOW_HALF_LAST;
         end else begin
            state_nxt.cnt = state_r.cnt - crs_pkg::SLOW_ONE;
         end
      end else begin
         state_nxt.clock_out_pin = ~state_r.clock_out_pin;
         state_nxt.cnt = crs_pkg::SLOW_ZERO;
      end
   end

   // Register the state.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign clk_if.clk_out = state_r.clock_out_pin;

endmodule
`default_nettype wire

// file: hdl/crs_pkg.sv
/*
  Constants shared by the chip reset and clock sequencing block: cycle
  counts, pin group layout, reset values and the slow clock settings.
  Assumes a single 250 MHz clock and that the internal clock period T is
  two cycles of that clock.
*/
// How it works
// - power-up clears the test-port controller automatically
// - reset with irq zero floats all pins except test data out
// - reset alone holds strobes high, clock runs
// - output clock period equals internal clock period
// - slow select runs output from slow clock
package crs_pkg;

   // -----------------------------------------------------------------
   // Clock and timing.
   // -----------------------------------------------------------------

   // Period of clock_i in nanoseconds.
   localparam int CLK_PERIOD_NS = 4;
   // Clock_i cycles in one internal clock period T.
   localparam int INT_DIV = 2;
   // Least chip reset pulse, in internal clock periods.
   localparam int RESET_MIN_T = 6;
   // Least chip reset pulse in clock_i cycles.
   localparam int RESET_MIN_CYC = RESET_MIN_T * INT_DIV;
   // Clock cycles the source gives while power-up reset is held.
   localparam int POWER_MIN_CYC = 6;
   // Slow clock period bounds and the period used, in nanoseconds.
   localparam int SLOW_PERIOD_MIN_NS = 740;
   localparam int SLOW_PERIOD_MAX_NS = 3800;
   localparam int SLOW_PERIOD_NS = 1000;
   // Half period of the slow clock in clock_i cycles, rounded down.
   localparam int SLOW_HALF_CYC = SLOW_PERIOD_NS / (2 * CLK_PERIOD_NS);

   // -----------------------------------------------------------------
   // Counter widths and sized counts.
   // -----------------------------------------------------------------

   localparam int CNT_W = 4;
   localparam int SLOW_W = 8;
   localparam logic [CNT_W-1:0] RESET_MIN_CNT = CNT_W'(RESET_MIN_CYC - 1);
   localparam logic [CNT_W-1:0] POWER_MIN_CNT = CNT_W'(POWER_MIN_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [SLOW_W-1:0] SLOW_HALF_LAST = SLOW_W'(SLOW_HALF_CYC - 1);
   localparam logic [SLOW_W-1:0] SLOW_ZERO = 8'h00;
   localparam logic [SLOW_W-1:0] SLOW_ONE = 8'h01;

   // -----------------------------------------------------------------
   // Pin groups.
   // -----------------------------------------------------------------

   // Strobe bit positions: ROM, RAM high, RAM low, I/O, select, rw.
   localparam int STB_W = 6;
   localparam int STB_ROM = 0;
   localparam int STB_RAMHI = 1;
   localparam int STB_RAMLO = 2;
   localparam int STB_IO = 3;
   localparam int STB_DEVICE_SELECT_OUT = 4;
   localparam int STB_RW = 5;
   localparam logic [STB_W-1:0] STB_IDLE = 6'h3f;
   // Data bus width.
   localparam int DATA_W = 16;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   // Synchroniser stage count and its cleared value (pin seen low).
   localparam int SYNC_W = 3;
   localparam logic [SYNC_W-1:0] SYNC_LOW = 3'h0;

endpackage

// file: hdl/crs_top.sv
/*
  Chip reset and clock sequencing top. Filters the chip reset and
  interrupt 0 pins, accepts a chip reset only after its least length,
  releases the core from reset on one clock edge, clears the test-port
  controller at power-up, and steers the memory strobes, data bus and
  output clock pads while reset is held.
  Assumes clock_i is the internal reference, nrst_i is the power-on
  reset, and core-side inputs come from logic on clock_i.
*/
`timescale 1ns/10ps
`default_nettype none
module crs_top (
   input  wire logic                       clock_i,             // Clock.
   input  wire logic                       nrst_i,              // Power-on.
   input  wire logic                       chip_reset_low_i,    // Pin.
   input  wire logic                       irq_line_zero_i,     // Pin.
   input  wire logic                       slow_clock_select_i, // Control.
   input  wire logic [crs_pkg::STB_W-1:0]  core_strobes_i,      // Core.
   input  wire logic [crs_pkg::DATA_W-1:0] core_data_i,         // Core.
   input  wire logic                       core_data_oe_i,      // Core.
   input  wire logic [crs_pkg::DATA_W-1:0] pad_data_i,          // Pad in.
   input  wire logic                       tdo_core_i,          // Test.
   input  wire logic                       tdo_oe_core_i,       // Test.
   output logic                            ext_rom_enable_o,
   output logic                            ext_ram_high_enable_o,
   output logic                            ext_ram_low_enable_o,
   output logic                            io_space_enable_o,
   output logic                            device_select_out_o,
   output logic                            read_write_low_o,
   output logic                            strobe_oe_o,
   output logic                            clock_out_pin_o,
   output logic                            clock_out_oe_o,
   output logic [crs_pkg::DATA_W-1:0]      data_o,
   output logic                            data_oe_o,
   output logic [crs_pkg::DATA_W-1:0]      core_data_o,
   output logic                            tdo_o,
   output logic                            tdo_oe_o,
   output logic                            core_reset_o,
   output logic                            test_ctrl_clear_o,
   output logic                            power_clocks_met_o
);

   // -----------------------------------------------------------------
   // Power-on reset release.
   // -----------------------------------------------------------------

   // Two-stage release of nrst_i; assertion is immediate, release
   // waits two edges so every flop leaves reset on the same edge.
   logic [1:0] rst_sync_r;   // Release shift register.
   logic       rst_n;        // Synchronised reset, active low.

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   // -----------------------------------------------------------------
   // Output clock generator.
   // -----------------------------------------------------------------

   crs_clk_if clk_if ();   // Carrier to the generator.

   // The control is on clock_i already, so it passes unsynchronised.
   assign clk_if.slow_sel = slow_clock_select_i;

   crs_clkgen u_clkgen (
      .clock_i (clock_i),
      .rst_n_i (rst_n),
      .clk_if  (clk_if)
   );

   // -----------------------------------------------------------------
   // State.
   // -----------------------------------------------------------------

   typedef struct packed {
      logic [crs_pkg::SYNC_W-1:0] rst_sync;   // Chip reset stages.
      logic [crs_pkg::SYNC_W-1:0] irq_sync;   // Interrupt 0 stages.
      logic                       rst_lvl;    // Filtered reset pin.
      logic                       irq_lvl;    // Filtered interrupt 0.
      logic [crs_pkg::CNT_W-1:0]  low_cnt;    // Reset low length.
      logic                       core_rst;   // Core held in reset.
      logic [crs_pkg::CNT_W-1:0]  pwr_cnt;    // Clocks seen in reset.
      logic                       pwr_met;    // Enough clocks seen.
      logic                       tclr;       // Test controller clear.
      logic [crs_pkg::STB_W-1:0]  stb;        // Strobe pads.
      logic                       stb_oe;     // Strobe pad enable.
      logic                       clock_out_pin;        // Output clock pad.
      logic                       cko_oe;     // Output clock enable.
      logic [crs_pkg::DATA_W-1:0] dout;       // Data pad out.
      logic                       dout_oe;    // Data pad enable.
      logic [crs_pkg::DATA_W-1:0] din;        // Data to the core.
      logic                       tdo;        // Test data out.
      logic                       tdo_oe;     // Test data out enable.
   } crs_top_s;

   crs_top_s state_r;     // Registered state.
   crs_top_s state_nxt;   // Next state.

   // Helper flags for the current cycle.
   logic chip_rst_held;   // Filtered reset pin is low.
   logic float_all;       // Reset and interrupt 0 both asserted.

   // Filters shared by both pin synchronisers: the filtered level
   // follows only once the second and third stages agree, so a single
   // stray sample never moves it.
   function automatic logic crs_filter(
      input logic [crs_pkg::SYNC_W-1:0] stages,
      input logic                       level
   );
      logic res;
      res = level;
      if (stages[1] == stages[2]) begin
         res = stages[2];
      end
      return res;
   endfunction

   // -----------------------------------------------------------------
   // Next-state logic.
   // -----------------------------------------------------------------

   // One pass computes pin filtering, reset acceptance and pad control.
   always_comb begin
      state_nxt = state_r;
      chip_rst_held = ~state_r.rst_lvl;
      float_all = chip_rst_held & state_r.irq_lvl;

      // Pins pass three stages; the first stage feeds only the second.
      state_nxt.rst_sync = {state_r.rst_sync[1:0], chip_reset_low_i};
      state_nxt.irq_sync = {state_r.irq_sync[1:0], irq_line_zero_i};
      state_nxt.rst_lvl = crs_filter(state_r.rst_sync, state_r.rst_lvl);
      state_nxt.irq_lvl = crs_filter(state_r.irq_sync, state_r.irq_lvl);

      // The clear pulse lasts only until the first edge after release.
      // power-up clear
      state_nxt.tclr = 1'b0;

      // A short low pulse is ignored; the count restarts each time the
      // pin goes high, so glitches cannot add up to a reset.
      // least reset length
      if (chip_rst_held) begin
         if (state_r.low_cnt == crs_pkg::RESET_MIN_CNT) begin
            state_nxt.core_rst = 1'b1;
         end else begin
            state_nxt.low_cnt = state_r.low_cnt + crs_pkg::CNT_ONE;
         end
      end else begin
         state_nxt.low_cnt = crs_pkg::CNT_ZERO;
         // Release happens on one edge for the whole core.
         // single release edge
         state_nxt.core_rst = 1'b0;
      end

      // Reports once the source has clocked the part long enough while
      // holding reset after power-up; the flag then stays set.
      // clocks during reset
      if (chip_rst_held && !state_r.pwr_met) begin
         if (state_r.pwr_cnt == crs_pkg::POWER_MIN_CNT) begin
            state_nxt.pwr_met = 1'b1;
         end else begin
            state_nxt.pwr_cnt = state_r.pwr_cnt + crs_pkg::CNT_ONE;
         end
      end

      // Test data out always follows the test port, even when all
      // other pads float.
      state_nxt.tdo = tdo_core_i;
      state_nxt.tdo_oe = tdo_oe_core_i;
      state_nxt.din = pad_data_i;
      state_nxt.clock_out_pin = clk_if.clk_out;

      // Pad control by reset and interrupt 0 state.
      // float all pads
      if (float_all) begin
         state_nxt.stb = crs_pkg::STB_IDLE;
         state_nxt.stb_oe = 1'b0;
         state_nxt.cko_oe = 1'b0;
         state_nxt.dout = crs_pkg::DATA_ZERO;
         state_nxt.dout_oe = 1'b0;
      end else if (chip_rst_held) begin
         state_nxt.stb = crs_pkg::STB_IDLE;
         state_nxt.stb_oe = 1'b1;
         state_nxt.cko_oe = 1'b1;
         state_nxt.dout = crs_pkg::DATA_ZERO;
         state_nxt.dout_oe = 1'b0;
      // Normal running: the core owns the pads.
      end else begin
         state_nxt.stb = core_strobes_i;
         state_nxt.stb_oe = 1'b1;
         state_nxt.cko_oe = 1'b1;
         state_nxt.dout = core_data_i;
         state_nxt.dout_oe = core_data_oe_i;
      end
   end

   // -----------------------------------------------------------------
   // State register.
   // -----------------------------------------------------------------

   // Reset leaves the core in reset, pads floating and the test
   // controller being cleared until the first edge after release.
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r          <= '0;
         state_r.rst_sync <= crs_pkg::SYNC_LOW;
         state_r.irq_sync <= crs_pkg::SYNC_LOW;
         state_r.core_rst <= 1'b1;
         state_r.tclr     <= 1'b1;
         state_r.stb      <= crs_pkg::STB_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Outputs, all straight from flops.
   // -----------------------------------------------------------------

   assign ext_rom_enable_o      = state_r.stb[crs_pkg::STB_ROM];
   assign ext_ram_high_enable_o = state_r.stb[crs_pkg::STB_RAMHI];
   assign ext_ram_low_enable_o  = state_r.stb[crs_pkg::STB_RAMLO];
   assign io_space_enable_o     = state_r.stb[crs_pkg::STB_IO];
   assign device_select_out_o   = state_r.stb[crs_pkg::STB_DEVICE_SELECT_OUT];
   assign read_write_low_o      = state_r.stb[crs_pkg::STB_RW];
   assign strobe_oe_o           = state_r.stb_oe;
   assign clock_out_pin_o       = state_r.clock_out_pin;
   assign clock_out_oe_o        = state_r.cko_oe;
   assign data_o                = state_r.dout;
   assign data_oe_o             = state_r.dout_oe;
   assign core_data_o           = state_r.din;
   assign tdo_o                 = state_r.tdo;
   assign tdo_oe_o              = state_r.tdo_oe;
   assign core_reset_o          = state_r.core_rst;
   assign test_ctrl_clear_o     = state_r.tclr;
   assign power_clocks_met_o    = state_r.pwr_met;

endmodule
`default_nettype wire

// file: testbench/crs_board_model.sv
/*
  Board reset source and test-port driver facing the sequencer pins.
  Assumes the bench calls drive just after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module crs_board_model (
   input  wire logic clock_i,          // Reference clock.
   output var logic  chip_reset_low_o, // Chip reset pin.
   output var logic  irq_line_zero_o,  // Interrupt 0 pin.
   output var logic  tck_o,            // Test clock, still between frames.
   output var logic  tms_o             // Test mode select.
);
   initial begin
      chip_reset_low_o = 1'b0;
      irq_line_zero_o = 1'b0;
      tck_o = 1'b0;
      tms_o = 1'b1;
   end

   task automatic drive(input logic rst_low, input logic irq);
      chip_reset_low_o = rst_low;
      irq_line_zero_o = irq;
   endtask

   task automatic test_port_clear;
      repeat (6) begin
         repeat (7) @(posedge clock_i);
         tck_o = 1'b1;
         repeat (7) @(posedge clock_i);
         tck_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// file: testbench/crs_top_properties.sv
/*
  Port checker for the sequencer top, bound irq_line_zero crs_top.
  Assumes pins hold a level for some clocks before a check counts.
*/
`timescale 1ns/10ps
`default_nettype none
module crs_top_properties (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic chip_reset_low_i,
   input wire logic irq_line_zero_i,
   input wire logic slow_clock_select_i,
   input wire logic tdo_core_i,
   input wire logic tdo_oe_core_i,
   input wire logic ext_rom_enable_o,
   input wire logic ext_ram_high_enable_o,
   input wire logic ext_ram_low_enable_o,
   input wire logic io_space_enable_o,
   input wire logic device_select_out_o,
   input wire logic read_write_low_o,
   input wire logic strobe_oe_o,
   input wire logic clock_out_pin_o,
   input wire logic clock_out_oe_o,
   input wire logic data_oe_o,
   input wire logic tdo_o,
   input wire logic tdo_oe_o,
   input wire logic core_reset_o,
   input wire logic test_ctrl_clear_o,
   input wire logic power_clocks_met_o
);
   // ----------
   // Helpers
   // ----------
   logic [4:0] up_r;     // Cycles since power-on release, saturating.
   logic [4:0] low_r;    // Consecutive samples of the reset pin low.
   logic [8:0] rate_r;   // Cycles spent on the present rate setting.
   logic [7:0] hold_r;   // Cycles the output clock kept its level.
   logic       slow_q_r; // Rate setting one cycle ago.
   logic       cko_q_r;  // Output clock one cycle ago.
   logic       up;       // Filters and counters have settled.
   logic       cko_chg;  // Output clock changed at this sample.
   assign up = (up_r == 5'h1f);
   assign cko_chg = (clock_out_pin_o != cko_q_r);

   // Restart with power-on so that no check sees stale history.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         up_r <= 5'h00;
         low_r <= 5'h00;
         rate_r <= 9'h000;
         hold_r <= 8'h00;
         slow_q_r <= 1'b0;
         cko_q_r <= 1'b0;
      end else begin
         up_r <= up ? up_r : up_r + 5'h01;
         low_r <= chip_reset_low_i ? 5'h00 :
                  (low_r == 5'h1f) ? low_r : low_r + 5'h01;
         rate_r <= (slow_clock_select_i != slow_q_r) ? 9'h000 :
                   (rate_r == 9'h1ff) ? rate_r : rate_r + 9'h001;
         hold_r <= cko_chg ? 8'h00 :
                   (hold_r == 8'hff) ? hold_r : hold_r + 8'h01;
         slow_q_r <= slow_clock_select_i;
         cko_q_r <= clock_out_pin_o;
      end
   end

   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   sequence both_s;
      (up && !chip_reset_low_i && irq_line_zero_i) [*6];
   endsequence
   sequence alone_s;
      (up && !chip_reset_low_i && !irq_line_zero_i) [*6];
   endsequence
   sequence release_s;
      up && core_reset_o && $rose(chip_reset_low_i) ##1
      chip_reset_low_i [*4];
   endsequence

   chk_float_both: assert property (
      both_s |-> !strobe_oe_o && !clock_out_oe_o && !data_oe_o)
      else $error("pads driven with reset and interrupt 0 held");
   chk_strobes_high: assert property (
      alone_s |-> ext_rom_enable_o && ext_ram_high_enable_o &&
      ext_ram_low_enable_o && io_space_enable_o && device_select_out_o &&
      read_write_low_o && strobe_oe_o && clock_out_oe_o && !data_oe_o)
      else $error("strobes not held high in reset");
   chk_tdo_free: assert property (
      up |-> tdo_o == $past(tdo_core_i) && tdo_oe_o == $past(tdo_oe_core_i))
      else $error("test data output was forced");
   chk_fast_clock: assert property (
      up && !slow_clock_select_i && rate_r >= 9'h12c |-> cko_chg)
      else $error("output clock missed a fast toggle");
   chk_slow_period: assert property (
      slow_clock_select_i && rate_r >= 9'h12c && cko_chg |->
      hold_r == 8'h7c)
      else $error("slow output clock half period wrong");
   chk_reset_accept: assert property (
      up && $rose(core_reset_o) |->
      !$past(chip_reset_low_i, 5) && !$past(chip_reset_low_i, 16))
      else $error("chip reset accepted from a short pulse");
   chk_reset_long: assert property (
      up && low_r >= 5'h10 |-> core_reset_o)
      else $error("long chip reset not accepted");
   chk_release_edge: assert property (
      release_s |-> core_reset_o ##1 !core_reset_o)
      else $error("core reset release off its edge");
   chk_power_met: assert property (
      up && low_r >= 5'h0a |-> power_clocks_met_o)
      else $error("clocks in reset not flagged");
   chk_power_sticky: assert property (
      power_clocks_met_o |=> power_clocks_met_o)
      else $error("clocks in reset flag dropped");
   chk_clear_done: assert property (
      $rose(nrst_i) |-> test_ctrl_clear_o ##[1:4] !test_ctrl_clear_o)
      else $error("test-port clear not ended after power-on");
endmodule

bind crs_top crs_top_properties chk_u (
   .clock_i, .nrst_i, .chip_reset_low_i, .irq_line_zero_i,
   .slow_clock_select_i, .tdo_core_i, .tdo_oe_core_i, .ext_rom_enable_o,
   .ext_ram_high_enable_o, .ext_ram_low_enable_o, .io_space_enable_o,
   .device_select_out_o, .read_write_low_o, .strobe_oe_o,
   .clock_out_pin_o, .clock_out_oe_o, .data_oe_o, .tdo_o, .tdo_oe_o,
   .core_reset_o, .test_ctrl_clear_o, .power_clocks_met_o
);
`default_nettype wire

// file: testbench/test_chip_reset_clock_sequencing.sv
/*
  Self-checking bench for the chip reset and clock sequencing top.
  Assumes the board model owns the reset and interrupt 0 pins.
*/
`timescale 1ns/10ps
`default_nettype none
module test_chip_reset_clock_sequencing;
   logic        clock_i, nrst_i, rst_low, irq0, slow_sel;
   logic [5:0]  stb_in, stb;          // Core strobes in, strobe pads out.
   logic [15:0] dat_in, dat_out;      // Core data in, data pads out.
   logic [15:0] pad_in, core_out;     // Data pad in, data to the core.
   logic        dat_oe_in, tdo_c, tdo_oe_c;
   logic        stb_oe, clock_out_pin, cko_oe, dat_oe, tdo, tdo_oe;
   logic        core_rst, tclr, pmet;
   int          n_fail, n_compared;

   crs_board_model board_u (.clock_i(clock_i), .chip_reset_low_o(rst_low),
      .irq_line_zero_o(irq0), .tck_o(), .tms_o());
   crs_top dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
      .chip_reset_low_i(rst_low), .irq_line_zero_i(irq0),
      .slow_clock_select_i(slow_sel), .core_strobes_i(stb_in),
      .core_data_i(dat_in), .core_data_oe_i(dat_oe_in),
      .pad_data_i(pad_in), .tdo_core_i(tdo_c), .tdo_oe_core_i(tdo_oe_c),
      .ext_rom_enable_o(stb[0]), .ext_ram_high_enable_o(stb[1]),
      .ext_ram_low_enable_o(stb[2]), .io_space_enable_o(stb[3]),
      .device_select_out_o(stb[4]), .read_write_low_o(stb[5]),
      .strobe_oe_o(stb_oe), .clock_out_pin_o(clock_out_pin), .clock_out_oe_o(cko_oe),
      .data_o(dat_out), .data_oe_o(dat_oe), .core_data_o(core_out),
      .tdo_o(tdo), .tdo_oe_o(tdo_oe), .core_reset_o(core_rst),
      .test_ctrl_clear_o(tclr), .power_clocks_met_o(pmet));

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   // ----------
   // Shared tasks
   // ----------
   task automatic check(input logic [15:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Inputs change one step after the edge, never on it.
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ----------
   // Scenarios
   // ----------
   task automatic s_power_up;
      cyc(40);
      check(tclr, 1'b0, "test clear");
      check(pmet, 1'b1, "clocks met");
      check(core_rst, 1'b1, "held");
      board_u.drive(1'b1, 1'b0);
      cyc(4);
      check(core_rst, 1'b1, "early");
      cyc(1);
      check(core_rst, 1'b0, "release");
   endtask
   // Pulse of n cycles; 12 is the shortest that counts.
   task automatic s_accept(input int n, input logic exp);
      board_u.drive(1'b0, 1'b0);
      cyc(n);
      board_u.drive(1'b1, 1'b0);
      cyc(4);
      check(core_rst, exp, "accept");
      cyc(1);
      check(core_rst, 1'b0, "leave");
      cyc(10);
   endtask
   task automatic s_pads(input logic irq);
      stb_in = irq ? 6'h2a : 6'h15;
      pad_in = irq ? 16'h0f0f : 16'hf0f0;
      tdo_oe_c = irq;
      board_u.drive(1'b0, irq);
      cyc(5);
      check({stb_oe, cko_oe, dat_oe}, irq ? 3'h0 : 3'h6, "enables");
      if (!irq) check(stb, 6'h3f, "strobes");
      check({tdo, tdo_oe}, {tdo_c, tdo_oe_c}, "test data");
      check(core_out, pad_in, "pad data");
      cyc(15);
      check(core_rst, 1'b1, "long reset");
      board_u.drive(1'b1, 1'b0);
      cyc(6);
      check({stb_oe, cko_oe, dat_oe}, 3'h7, "run enables");
      check(stb, stb_in, "core strobes");
      check(dat_out, dat_in, "core data");
      tdo_c = ~tdo_c;
   endtask
   task automatic s_clock;
      logic prev;
      int   n;
      for (int i = 0; i < 4; i++) begin
         prev = clock_out_pin;
         cyc(1);
         check(clock_out_pin, !prev, "fast toggle");
      end
      slow_sel = 1'b1;
      cyc(300);
      for (int k = 0; k < 2; k++) begin
         prev = clock_out_pin;
         n = 0;
         while (clock_out_pin === prev && n < 300) begin
            cyc(1);
            n++;
         end
      end
      check(16'(n), 16'h007d, "slow half period");
      slow_sel = 1'b0;
      cyc(300);
   endtask

   initial begin
      n_fail = 0;
      n_compared = 0;
      nrst_i = 1'b0;
      slow_sel = 1'b0;
      stb_in = 6'h15;
      dat_in = 16'h5a3c;
      pad_in = 16'h0f0f;
      dat_oe_in = 1'b1;
      tdo_c = 1'b1;
      tdo_oe_c = 1'b0;
      repeat (6) @(posedge clock_i);
      #1;
      nrst_i = 1'b1;
      board_u.test_port_clear();
      s_power_up();
      s_accept(11, 1'b0);
      s_accept(12, 1'b1);
      s_pads(1'b0);
      s_pads(1'b1);
      s_clock();
      tally_and_finish();
   end

   // The run needs some 1100 cycles; far beyond that is a hang.
   initial begin
      #20000;
      n_fail++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
